// ===== src/ssbr_pkg.sv
// Purpose: Shared constants for the sensor serial burst read link.
// Assumes: 100 MHz system clock on both ends, SPI mode 3, 16-bit frames.
// Notes:   Word indices are register addresses divided by two.
package ssbr_pkg;
   //***********************************************************
   // Link framing
   //***********************************************************
   localparam logic [3:0]  FRAME_LAST_BIT = 4'hf;
   localparam logic [15:0] BURST_CMD      = 16'h6800;
   localparam logic [15:0] IDLE_WORD      = 16'h0000;
   localparam int          SYS_CLK_HZ     = 100000000;
   localparam int          SCLK_MAX_HZ    = 1000000;
   // Least half period, rounded up so SCLK never exceeds the limit
   localparam int          HALF_CYC       =
      (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam logic [6:0]  HALF_LAST      = 7'(HALF_CYC - 1);

   //***********************************************************
   // Device configuration fields
   //***********************************************************
   localparam int          MODE_LSB       = 2;
   localparam int          MODE_MSB       = 4;
   localparam logic [2:0]  MODE_SCALED    = 3'h2;
   localparam logic [15:0] FW_WIDE_MIN    = 16'h0134;

   //***********************************************************
   // Register word indices
   //***********************************************************
   localparam logic [5:0]  DIAG_IDX       = 6'h01;
   localparam logic [5:0]  RATE_X_LOW_IDX = 6'h02;
   localparam logic [5:0]  TEMP_IDX       = 6'h0e;
   localparam logic [5:0]  STAMP_IDX      = 6'h0f;
   localparam logic [5:0]  COUNT_IDX      = 6'h11;
   localparam logic [5:0]  ANGLE_X_LOW_IDX = 6'h12;
   localparam logic [4:0]  NARROW_DATA    = 5'h06;
   localparam logic [4:0]  WIDE_DATA      = 5'h0c;
   localparam int          REG_WORDS      = 64;

   //***********************************************************
   // Host command port map
   //***********************************************************
   localparam logic [4:0]  HOST_READ_OFS   = 5'h00;
   localparam logic [4:0]  HOST_BURST_OFS  = 5'h01;
   localparam logic [4:0]  HOST_STATUS_OFS = 5'h02;
   localparam logic [4:0]  HOST_RDATA_OFS  = 5'h03;
   localparam int          BUF_WORDS       = 16;
   localparam int          ST_BUSY_BIT     = 0;
   localparam int          ST_DONE_BIT     = 1;
   localparam int          ST_CSUM_BIT     = 2;
endpackage

// ===== src/ssbr_if.sv
// Purpose: Four-wire serial link between sensor end and host end.
// Assumes: Host drives clock, select and command line.
// Notes:   Plain wires, no clocking; each end samples with its own clock.
`timescale 1ns/100ps
interface ssbr_if;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   modport dev  (input sclk, input cs_n, input mosi, output miso);
   modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// ===== src/ssbr_dev.sv
// Purpose: Sensor end of the serial link: register reads and burst read.
// Assumes: Link pins are asynchronous and sampled twice before use.
// Notes:   Write frames are accepted on the wire and ignored.
// Functional notes
// (R1) Register read spans two 16-bit frames
// (R2) Read request: bit15 zero, byte address, ignored
// (R3) Full duplex: reply shifts while request arrives
// (R4) Burst starts on 0x6800, select low, 1 MHz
// (R5) Burst words stream with no gaps
// (R6) Clock mode field selects burst content
// (R7) Non scaled modes end with counter, checksum
// (R8) Scaled sync sends timestamp instead of counter
// (R9) Wide and select need firmware 1.34 onward
// (R10) Narrow select0: diag, rate, accel highs, temp
// (R11) Narrow select1: diag, angle, velocity highs, temp
// (R12) Wide select0: rate, accel low then high
// (R13) Wide select1: angle, velocity low then high
// (R14) Checksum sums bytes of preceding words
// (R15) Host disables linear-g with narrow select0
// (R16) Host prefers wide select0 for linear-g
// (R17) Mode 3, MSB first, 16-bit frames
// (R18) 16-bit registers, each byte addressable
// (R19) Write frame has bit15 set
// (R20) Select rise aborts burst, next frame command
`timescale 1ns/100ps
module ssbr_dev
   import ssbr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   ssbr_if.dev              spi,
   input  wire logic        reg_wr_en,
   input  wire logic [5:0]  reg_wr_index,
   input  wire logic [15:0] reg_wr_data,
   input  wire logic [15:0] misc_control_reg,
   input  wire logic        burst_sel,
   input  wire logic        burst_wide_words,
   input  wire logic [15:0] firmware_revision,
   output logic             burst_active
);
   import ssbr_pkg::*;

   //***********************************************************
   // Pin synchronisers and edge detect
   //***********************************************************
   logic [2:0]  meta_ff;
   logic [2:0]  sync_ff;
   logic [1:0]  prev_ff;
   logic        sclk_s;
   logic        cs_s;
   logic        mosi_s;
   logic        sclk_fall;
   logic        sclk_rise;
   logic        cs_rise;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         meta_ff <= 3'h3;
         sync_ff <= 3'h3;
         prev_ff <= 2'h3;
      end else begin
         meta_ff <= {spi.mosi, spi.cs_n, spi.sclk};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff[1:0];
      end
   end

   assign sclk_s    = sync_ff[0];
   assign cs_s      = sync_ff[1];
   assign mosi_s    = sync_ff[2];
   // Mode 3: drive on falling, sample on rising [R17]
   assign sclk_fall = prev_ff[0] & ~sclk_s & ~cs_s;
   assign sclk_rise = ~prev_ff[0] & sclk_s & ~cs_s;
   assign cs_rise   = ~prev_ff[1] & cs_s;

   //***********************************************************
   // Register storage, loaded by the sensing logic
   //***********************************************************
   logic [15:0] regs_ff [REG_WORDS];

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         for (int i = 0; i < REG_WORDS; i++) begin
            regs_ff[i] <= 16'h0000;
         end
      end else if (reg_wr_en) begin
         regs_ff[reg_wr_index] <= reg_wr_data;
      end
   end

   //***********************************************************
   // Frame shifter
   //***********************************************************
   logic [3:0]  bit_cnt_ff;
   logic [15:0] rx_ff;
   logic [15:0] tx_ff;
   logic        miso_ff;
   logic        frame_end;
   logic [15:0] word_in;

   assign frame_end = sclk_rise && (bit_cnt_ff == FRAME_LAST_BIT);
   assign word_in   = {rx_ff[14:0], mosi_s};

   always_ff @(posedge clk_sys) begin
      if (!rstn || cs_s) begin
         bit_cnt_ff <= 4'h0;
      end else if (sclk_rise) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rx_ff <= 16'h0000;
      end else if (sclk_rise) begin
         rx_ff <= word_in; // MSB first [R17]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || cs_s) begin
         miso_ff <= 1'b0;
      end else if (sclk_fall) begin
         miso_ff <= tx_ff[4'hf - bit_cnt_ff]; // [R3]
      end
   end

   assign spi.miso = miso_ff;

   //***********************************************************
   // Burst sequencing
   //***********************************************************
   logic        burst_ff;
   logic [4:0]  idx_ff;
   logic [15:0] csum_ff;
   logic        sel_ff;
   logic        wide_ff;
   logic [2:0]  mode_ff;
   logic        nxt_burst;
   logic [4:0]  nxt_idx;
   logic [15:0] nxt_csum;
   logic [15:0] nxt_tx;
   logic        nxt_sel;
   logic        nxt_wide;
   logic        wide_ok;
   logic        cmd_frame;
   logic [4:0]  last_idx;
   logic [15:0] word_out;

   function automatic logic [15:0] byte_sum(input logic [15:0] w);
      return {8'h00, w[15:8]} + {8'h00, w[7:0]}; // [R14]
   endfunction

   // Word index of the n-th burst word
   function automatic logic [5:0] burst_index(input logic [4:0] n,
                                              input logic       sel,
                                              input logic       wide,
                                              input logic [2:0] mode);
      logic [4:0] data_words;
      logic [5:0] base;
      logic [5:0] k;
      data_words = wide ? WIDE_DATA : NARROW_DATA;
      base       = sel ? ANGLE_X_LOW_IDX : RATE_X_LOW_IDX; // [R11] [R13]
      k          = {1'b0, n} - 6'h01;
      if (n == 5'h00) begin
         return DIAG_IDX;
      end else if (n <= data_words) begin
         // Low then high per axis, or high words only [R12] [R10]
         return wide ? base + k : base + {k[4:0], 1'b1};
      end else if (n == data_words + 5'h01) begin
         return TEMP_IDX;
      end else begin
         // Counter or timestamp as the last data word [R7] [R8]
         return (mode == MODE_SCALED) ? STAMP_IDX : COUNT_IDX;
      end
   endfunction

   // Older firmware only knows the narrow select0 burst [R9]
   assign wide_ok   = firmware_revision >= FW_WIDE_MIN;
   assign nxt_sel   = burst_sel & wide_ok;
   assign nxt_wide  = burst_wide_words & wide_ok;
   assign last_idx  = (wide_ff ? WIDE_DATA : NARROW_DATA) + 5'h03;
   // After the checksum frame the incoming word is a command again
   assign cmd_frame = !burst_ff || (idx_ff > last_idx);
   assign word_out  = regs_ff[burst_index(idx_ff, sel_ff, wide_ff,
                                          mode_ff)];

   always_comb begin
      nxt_burst = burst_ff;
      nxt_idx   = idx_ff;
      nxt_csum  = csum_ff;
      nxt_tx    = tx_ff;
      if (cmd_frame) begin
         nxt_burst = 1'b0;
         if (word_in == BURST_CMD) begin // [R4]
            nxt_burst = 1'b1;
            nxt_idx   = 5'h01;
            nxt_tx    = regs_ff[burst_index(5'h00, nxt_sel, nxt_wide,
                        misc_control_reg[MODE_MSB:MODE_LSB])]; // [R6]
            nxt_csum  = byte_sum(nxt_tx);
         end else if (!word_in[15]) begin
            // Byte address, either byte of the word [R2] [R18] [R1]
            nxt_tx = regs_ff[word_in[14:9]];
         end else begin
            nxt_tx = IDLE_WORD; // Write frame ignored [R19]
         end
      end else if (idx_ff == last_idx) begin
         nxt_tx  = csum_ff; // [R14]
         nxt_idx = idx_ff + 5'h01;
      end else begin
         // Next word loads at frame end, no stall [R5]
         nxt_tx   = word_out;
         nxt_csum = csum_ff + byte_sum(word_out);
         nxt_idx  = idx_ff + 5'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         burst_ff <= 1'b0;
         idx_ff   <= 5'h00;
         csum_ff  <= 16'h0000;
         tx_ff    <= IDLE_WORD;
      end else if (cs_rise && burst_ff) begin
         burst_ff <= 1'b0; // Abandon the unfinished burst [R20]
         idx_ff   <= 5'h00;
         tx_ff    <= IDLE_WORD;
      end else if (frame_end) begin
         burst_ff <= nxt_burst;
         idx_ff   <= nxt_idx;
         csum_ff  <= nxt_csum;
         tx_ff    <= nxt_tx;
      end
   end

   // Options frozen for the whole burst
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         sel_ff  <= 1'b0;
         wide_ff <= 1'b0;
         mode_ff <= 3'h0;
      end else if (frame_end && cmd_frame && word_in == BURST_CMD) begin
         sel_ff  <= nxt_sel;
         wide_ff <= nxt_wide;
         mode_ff <= misc_control_reg[MODE_MSB:MODE_LSB]; // [R6]
      end
   end

   assign burst_active = burst_ff;
endmodule

// ===== src/ssbr_host.sv
// Purpose: Host end: issues register reads and bursts, checks checksum.
// Assumes: Software gives the burst length in words incl. checksum.
// Notes:   Select stays low across all frames of one transaction.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module ssbr_host
   import ssbr_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   ssbr_if.host             spi,
   input  wire logic [4:0]  cmd_addr,
   input  wire logic [15:0] cmd_wdata,
   input  wire logic        cmd_wr,
   input  wire logic        cmd_rd,
   output logic [15:0]      cmd_rdata
);
   import ssbr_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP
   } ssbr_hstate_t;

   //***********************************************************
   // Pin input synchroniser
   //***********************************************************
   logic meta_ff;
   logic miso_s_ff;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         meta_ff   <= 1'b0;
         miso_s_ff <= 1'b0;
      end else begin
         meta_ff   <= spi.miso;
         miso_s_ff <= meta_ff;
      end
   end

   //***********************************************************
   // Link engine
   //***********************************************************
   ssbr_hstate_t state_ff;
   logic [6:0]  div_ff;
   logic [3:0]  bit_ff;
   logic [4:0]  frame_ff;
   logic [4:0]  frames_ff;
   logic        is_burst_ff;
   logic [15:0] tx_ff;
   logic [15:0] rx_ff;
   logic        sclk_ff;
   logic        cs_n_ff;
   logic        mosi_ff;
   logic        half_done;
   logic        start_rd;
   logic        start_burst;
   logic        frame_done;

   assign half_done   = div_ff == HALF_LAST;
   assign start_rd    = cmd_wr && cmd_addr == HOST_READ_OFS;
   assign start_burst = cmd_wr && cmd_addr == HOST_BURST_OFS;
   assign frame_done  = state_ff == H_HIGH && half_done &&
                        bit_ff == FRAME_LAST_BIT;

   always_ff @(posedge clk_sys) begin
      if (!rstn || state_ff == H_IDLE || half_done) begin
         div_ff <= 7'h00;
      end else begin
         div_ff <= div_ff + 7'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_ff    <= H_IDLE;
         sclk_ff     <= 1'b1; // Idle high [R17]
         cs_n_ff     <= 1'b1;
         mosi_ff     <= 1'b0;
         bit_ff      <= 4'h0;
         frame_ff    <= 5'h00;
         frames_ff   <= 5'h00;
         is_burst_ff <= 1'b0;
         tx_ff       <= IDLE_WORD;
         rx_ff       <= 16'h0000;
      end else begin
         unique case (state_ff)
            H_IDLE: begin
               if (start_rd || start_burst) begin
                  state_ff    <= H_LEAD;
                  cs_n_ff     <= 1'b0; // Low for whole burst [R4]
                  bit_ff      <= 4'h0;
                  frame_ff    <= 5'h00;
                  is_burst_ff <= start_burst;
                  // Request then one reply frame [R1]
                  frames_ff   <= start_burst ?
                                 cmd_wdata[4:0] + 5'h01 : 5'h02;
                  // Read bit clear, byte address, don't care [R2]
                  // Never sends a write frame, bit 15 stays low [R19]
                  tx_ff       <= start_burst ? BURST_CMD :
                                 {1'b0, cmd_wdata[6:0], 8'h00};
               end
            end
            H_LEAD: begin
               if (half_done) begin
                  state_ff <= H_LOW;
                  sclk_ff  <= 1'b0;
                  mosi_ff  <= tx_ff[15]; // MSB first [R17]
               end
            end
            H_LOW: begin
               if (half_done) begin
                  state_ff <= H_HIGH;
                  sclk_ff  <= 1'b1;
                  rx_ff    <= {rx_ff[14:0], miso_s_ff};
               end
            end
            H_HIGH: begin
               if (half_done) begin
                  if (frame_done && frame_ff == frames_ff - 5'h01) begin
                     state_ff <= H_TAIL;
                  end else if (frame_done) begin
                     // Next frame follows with no stall [R5]
                     state_ff <= H_LOW;
                     sclk_ff  <= 1'b0;
                     bit_ff   <= 4'h0;
                     frame_ff <= frame_ff + 5'h01;
                     tx_ff    <= IDLE_WORD;
                     mosi_ff  <= 1'b0;
                  end else begin
                     state_ff <= H_LOW;
                     sclk_ff  <= 1'b0;
                     bit_ff   <= bit_ff + 4'h1;
                     tx_ff    <= {tx_ff[14:0], 1'b0};
                     mosi_ff  <= tx_ff[14];
                  end
               end
            end
            H_TAIL: begin
               if (half_done) begin
                  state_ff <= H_GAP;
                  cs_n_ff  <= 1'b1;
               end
            end
            H_GAP: begin
               // Select high long enough for the far end to see it
               if (half_done) begin
                  state_ff <= H_IDLE;
               end
            end
         endcase
      end
   end

   assign spi.sclk = sclk_ff;
   assign spi.cs_n = cs_n_ff;
   assign spi.mosi = mosi_ff;

   //***********************************************************
   // Received words, checksum check, status
   //***********************************************************
   logic [15:0] buf_ff [BUF_WORDS];
   logic [15:0] rdata_ff;
   logic [15:0] acc_ff;
   logic        csum_ok_ff;
   logic        done_ff;
   logic        last_frame;

   assign last_frame = frame_ff == frames_ff - 5'h01;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         for (int i = 0; i < BUF_WORDS; i++) begin
            buf_ff[i] <= 16'h0000;
         end
      end else if (frame_done && is_burst_ff && frame_ff != 5'h00
                   && frame_ff <= 5'(BUF_WORDS)) begin
         buf_ff[4'(frame_ff - 5'h01)] <= rx_ff;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rdata_ff   <= 16'h0000;
         acc_ff     <= 16'h0000;
         csum_ok_ff <= 1'b0;
         done_ff    <= 1'b0;
      end else if (state_ff == H_IDLE && (start_rd || start_burst)) begin
         acc_ff     <= 16'h0000;
         csum_ok_ff <= 1'b0;
         done_ff    <= 1'b0;
      end else if (frame_done && frame_ff != 5'h00) begin
         if (!is_burst_ff) begin
            rdata_ff <= rx_ff; // Reply in the frame after [R1]
         end else if (last_frame) begin
            csum_ok_ff <= acc_ff == rx_ff; // [R14]
         end else begin
            acc_ff <= acc_ff + {8'h00, rx_ff[15:8]}
                      + {8'h00, rx_ff[7:0]};
         end
         done_ff <= last_frame;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || !cmd_rd) begin
         cmd_rdata <= 16'h0000;
      end else if (cmd_addr[4]) begin
         cmd_rdata <= buf_ff[cmd_addr[3:0]];
      end else if (cmd_addr == HOST_STATUS_OFS) begin
         cmd_rdata <= {13'h0000, csum_ok_ff, done_ff,
                       state_ff != H_IDLE};
      end else if (cmd_addr == HOST_RDATA_OFS) begin
         cmd_rdata <= rdata_ff;
      end else begin
         cmd_rdata <= 16'h0000;
      end
   end
endmodule

// ===== sim/ssbr_chk.sv
// Purpose: Link-level checks between the sensor end and the host end.
// Assumes: Sees the four link wires plus the device burst flag.
// Notes:   Burst flag lags the wires by the device's input sync.
`timescale 1ns/100ps
module ssbr_chk
   import ssbr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic burst_active
);
   //***********************************************************
   // Helper counters
   //***********************************************************
   logic [7:0] half_cnt_ff;
   logic [8:0] rise_cnt_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   always_ff @(posedge clk_sys) begin
      if (!rstn || $changed(sclk)) begin
         half_cnt_ff <= 8'h00;
      end else if (half_cnt_ff != 8'hff) begin
         half_cnt_ff <= half_cnt_ff + 8'h01;
      end
   end

   // Rises counted per select, so burst length is per transaction
   always_ff @(posedge clk_sys) begin
      if (!rstn || $fell(cs_n)) begin
         rise_cnt_ff <= 9'h000;
      end else if ($rose(sclk)) begin
         rise_cnt_ff <= rise_cnt_ff + 9'h001;
      end
   end

   //***********************************************************
   // Assertions
   //***********************************************************
   a_sclk_idle_high: assert property (cs_n |-> sclk)
      else $error("serial clock not high while deselected");
   a_sclk_half_min: assert property (
      $changed(sclk) |-> half_cnt_ff >= 8'(HALF_LAST))
      else $error("serial clock half period too short");
   a_mosi_on_fall: assert property (
      $changed(mosi) && !cs_n && $past(!cs_n) |-> $fell(sclk))
      else $error("host data changed off the falling clock");
   a_miso_held_rise: assert property (
      $rose(sclk) && !cs_n |-> $stable(miso) [*8])
      else $error("device data moved near the sampling edge");
   a_miso_quiet_idle: assert property (cs_n [*5] |-> !miso)
      else $error("device data not low while deselected");
   a_burst_needs_cs: assert property ($rose(burst_active) |-> !cs_n)
      else $error("burst began without select");
   a_burst_after_cmd: assert property (
      $rose(burst_active) |-> rise_cnt_ff == 9'd16)
      else $error("burst began outside the first frame");
   a_burst_len_ok: assert property (
      $fell(burst_active) |-> rise_cnt_ff inside {9'd176, 9'd272})
      else $error("burst ended after a wrong number of bits");
   a_burst_abort: assert property (cs_n [*6] |-> !burst_active)
      else $error("burst still active after select rose");
endmodule

// ===== sim/sensor_spi_burst_read_test.sv
// Purpose: Self-checking bench joining host end and sensor end.
// Assumes: Host command port and device register port driven here.
// Notes:   Expected words come from a fixed fill pattern.
`timescale 1ns/100ps
module sensor_spi_burst_read_test;
   import ssbr_pkg::*;
   //***********************************************************
   // Signals and instances
   //***********************************************************
   logic        clk_sys, rstn, reg_wr_en, burst_sel, burst_wide_words;
   logic        cmd_wr, cmd_rd;
   logic [5:0]  reg_wr_index;
   logic [15:0] reg_wr_data, misc_control_reg, firmware_revision;
   logic [15:0] cmd_wdata, cmd_rdata;
   logic [4:0]  cmd_addr;
   logic        burst_active;
   int          n_fail, n_tests;

   ssbr_if spi ();
   ssbr_dev u_ssbr_dev (.clk_sys(clk_sys), .rstn(rstn), .spi(spi),
      .reg_wr_en(reg_wr_en), .reg_wr_index(reg_wr_index),
      .reg_wr_data(reg_wr_data), .misc_control_reg(misc_control_reg),
      .burst_sel(burst_sel), .burst_wide_words(burst_wide_words),
      .firmware_revision(firmware_revision),
      .burst_active(burst_active));
   ssbr_host u_ssbr_host (.clk_sys(clk_sys), .rstn(rstn), .spi(spi),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
   ssbr_chk u_ssbr_chk (.clk_sys(clk_sys), .rstn(rstn), .sclk(spi.sclk),
      .cs_n(spi.cs_n), .mosi(spi.mosi), .miso(spi.miso),
      .burst_active(burst_active));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   //***********************************************************
   // Shared tasks
   //***********************************************************
   function automatic logic [15:0] wv(input logic [5:0] i);
      wv = {8'(i) + 8'h40, 8'(i) * 8'h07 + 8'h11};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      cmd_addr  <= a;
      cmd_wdata <= d;
      cmd_wr    <= 1'b1;
      @(posedge clk_sys);
      cmd_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      cmd_addr <= a;
      cmd_rd   <= 1'b1;
      @(posedge clk_sys);
      cmd_rd   <= 1'b0;
      @(negedge clk_sys);
      d = cmd_rdata;
   endtask

   // Bounded poll; the watchdog catches a host that never finishes
   task automatic wait_done();
      logic [15:0] d;
      repeat (4) @(posedge clk_sys);
      for (int k = 0; k < 40000; k++) begin
         rd(HOST_STATUS_OFS, d);
         if (d[ST_DONE_BIT] === 1'b1 && d[ST_BUSY_BIT] === 1'b0) break;
      end
   endtask

   task automatic run_burst(input logic s, input logic w,
                            input logic [2:0] m, input logic [15:0] fw);
      logic [15:0] d, e, sum;
      logic [5:0]  idx, base;
      logic        es, ew;
      int          n;
      es = s && (fw >= FW_WIDE_MIN);
      ew = w && (fw >= FW_WIDE_MIN);
      n = ew ? 16 : 10;
      base = es ? ANGLE_X_LOW_IDX : RATE_X_LOW_IDX;
      @(posedge clk_sys);
      burst_sel         <= s;
      burst_wide_words  <= w;
      misc_control_reg  <= 16'(m) << MODE_LSB;
      firmware_revision <= fw;
      wr(HOST_BURST_OFS, 16'(n));
      wait_done();
      rd(HOST_STATUS_OFS, d);
      check(d & 16'h0007, 16'h0006);
      sum = 16'h0000;
      for (int i = 0; i < n; i++) begin
         if (i == 0) idx = DIAG_IDX;
         else if (i < n - 3)
            idx = base + (ew ? 6'(i - 1) : 6'(2 * i - 1));
         else if (i == n - 3) idx = TEMP_IDX;
         else idx = (m == MODE_SCALED) ? STAMP_IDX : COUNT_IDX;
         e = (i == n - 1) ? sum : wv(idx);
         sum = sum + 16'(e[15:8]) + 16'(e[7:0]);
         rd(5'h10 + 5'(i), d);
         check(d, e);
      end
   endtask

   //***********************************************************
   // Scenarios
   //***********************************************************
   task automatic t_single_read();
      logic [15:0] d;
      wr(HOST_READ_OFS, 16'h0019);
      wait_done();
      rd(HOST_RDATA_OFS, d);
      check(d, wv(6'h0c));
      wr(HOST_READ_OFS, 16'h0018);
      wait_done();
      rd(HOST_RDATA_OFS, d);
      check(d, wv(6'h0c));
   endtask

   // Old firmware must fall back to narrow rate/accel words
   // Control bits beyond the mode field, linear-g included, stay clear
   task automatic t_old_fw();
      run_burst(1'b1, 1'b1, 3'h0, 16'h0133);
   endtask

   task automatic t_narrow_scaled();
      run_burst(1'b1, 1'b0, MODE_SCALED, 16'h0134);
   endtask

   task automatic t_wide_rate();
      run_burst(1'b0, 1'b1, 3'h1, 16'h0200);
   endtask

   task automatic t_wide_angle_scaled();
      run_burst(1'b1, 1'b1, MODE_SCALED, 16'h0134);
   endtask

   //***********************************************************
   // Main sequence and watchdog
   //***********************************************************
   initial begin
      n_fail = 0;
      n_tests = 0;
      rstn = 1'b0;
      reg_wr_en = 1'b0;
      reg_wr_index = 6'h00;
      reg_wr_data = 16'h0000;
      misc_control_reg = 16'h0000;
      burst_sel = 1'b0;
      burst_wide_words = 1'b0;
      firmware_revision = 16'h0134;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      cmd_addr = 5'h00;
      cmd_wdata = 16'h0000;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         @(posedge clk_sys);
         reg_wr_en    <= 1'b1;
         reg_wr_index <= 6'(i);
         reg_wr_data  <= wv(6'(i));
      end
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
      repeat (6) @(posedge clk_sys);
      t_single_read();
      t_old_fw();
      t_narrow_scaled();
      t_wide_rate();
      t_wide_angle_scaled();
      results();
   end

   // Clean run needs about 97k cycles, so this leaves a small margin
   initial begin
      repeat (104000) @(posedge clk_sys);
      n_fail++;
      results();
   end
endmodule
